// File: logic/pti_pkg.sv
// Shared constants and carrier types of the proximity interrupt block
package pti_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int CNT_W  = 12;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONF2 = 8'h03;
    localparam logic [7:0] ADDR_THDL  = 8'h04;
    localparam logic [7:0] ADDR_THDH  = 8'h05;
    localparam logic [7:0] ADDR_LP    = 8'h08;
    localparam logic [7:0] ADDR_MASK  = 8'h10;
    localparam logic [7:0] ADDR_DATA  = 8'hf8;
    localparam logic [7:0] ADDR_FLAG  = 8'hf9;
    localparam logic [7:0] ADDR_ID    = 8'hfa;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int METH_LSB  = 2;
    localparam int PERS_LSB  = 4;
    localparam int LPEN_BIT  = 8;
    localparam int LPPER_LSB = 9;
    localparam int AWAY_BIT  = 8;
    localparam int CLOSE_BIT = 9;

    // Method select codes
    localparam logic [1:0] METH_OFF    = 2'h0;
    localparam logic [1:0] METH_LOGIC  = 2'h1;
    localparam logic [1:0] METH_FIRST  = 2'h2;
    localparam logic [1:0] METH_NORMAL = 2'h3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0]  RST_METH = METH_OFF;
    localparam logic [1:0]  RST_MASK = 2'h3;
    localparam logic [11:0] RST_THDH = 12'hfff;
    // Arbitrary neutral identity value
    localparam logic [15:0] DEVICE_ID = 16'h005a;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ      = 10_000_000;
    localparam int LP_BASE_MS  = 40;
    localparam int LP_BASE_CYC = LP_BASE_MS * (CLK_HZ / 1000);
    localparam int LP_CNT_W    = 22;

    // Register port request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_s;

    // One proximity measurement
    typedef struct packed {
        logic             valid;
        logic [CNT_W-1:0] count;
    } meas_s;

endpackage // pti_pkg

// File: logic/pti_lp_timer.sv
// Low-power measurement period divider
module pti_lp_timer #(
    parameter int unsigned BASE_CYC = pti_pkg::LP_BASE_CYC
) (
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       rstn_in,
    // Control
    input  wire logic       en_in,
    input  wire logic [1:0] per_in,
    // Measurement request pulse
    output logic            tick_out
);
    localparam int CW = pti_pkg::LP_CNT_W;

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          tick;
    } pti_tmr_s;

    pti_tmr_s st_reg;
    pti_tmr_s st_next;

    // Last count of a period: base doubled per select step
    function automatic logic [CW-1:0] last_of(input logic [1:0] p);
        return CW'((BASE_CYC << p) - 1);
    endfunction

    // Free count while enabled, restart from zero when idle
    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (!en_in) begin
            st_next.cnt = '0;
        end else if (st_reg.cnt >= last_of(per_in)) begin
            st_next.cnt = '0;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + CW'(1);
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick_out = st_reg.tick;

    // Tick only at the end of the selected period
    tick_period_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        st_reg.tick |-> $past(st_reg.cnt) == last_of($past(per_in)))
        else $error("period tick at wrong count");
    idle_no_tick_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        !en_in |=> !st_reg.tick)
        else $error("tick while low power is off");

endmodule // pti_lp_timer

// File: logic/pti_persist.sv
// Consecutive-measurement persistence filter
module pti_persist (
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       rstn_in,
    // Measurement step and compare result
    input  wire logic       step_in,
    input  wire logic       hit_in,
    input  wire logic [1:0] pers_in,
    // One-cycle event when the run is long enough
    output logic            fire_out
);
    typedef struct packed {
        logic [2:0] run;
        logic       fire;
    } pti_pers_s;

    pti_pers_s st_reg;
    pti_pers_s st_next;

    // Field 0..3 means 1..4 consecutive hits
    function automatic logic [2:0] need_of(input logic [1:0] p);
        return {1'b0, p} + 3'h1;
    endfunction

    // Run saturates at the need so one run fires once
    always_comb begin
        st_next = st_reg;
        st_next.fire = 1'b0;
        if (step_in) begin
            if (!hit_in) begin
                st_next.run = '0;
            end else if (st_reg.run < need_of(pers_in)) begin
                st_next.run = st_reg.run + 3'h1;
                st_next.fire = (st_next.run == need_of(pers_in));
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign fire_out = st_reg.fire;

    fire_run_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        st_reg.fire |-> st_reg.run == need_of($past(pers_in)))
        else $error("persistence fired with wrong run");

endmodule // pti_persist

// File: logic/pti_prox_irq.sv
// Proximity threshold interrupt core with its register file
// ---------------------------------------------------------------
// ---------------------------------------------------------------
//
// Added by the designer: strobed register access and the address map.
module pti_prox_irq #(
    parameter int unsigned LP_BASE_CYC = pti_pkg::LP_BASE_CYC
) (
    // Clock and reset
    input  wire logic                      mclk_in,
    input  wire logic                      rstn_in,
    // Register port
    input  wire pti_pkg::bus_req_s         bus_in,
    output logic [pti_pkg::DATA_W-1:0]     rdata_out,
    // Measurement side
    input  wire pti_pkg::meas_s            meas_in,
    output logic                           meas_req_out,
    // Interrupt
    output logic                           int_n_out,
    output logic                           irq_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]                  meth;
        logic [1:0]                  pers;
        logic [11:0]                 thdl;
        logic [11:0]                 thdh;
        logic                        lpen;
        logic [1:0]                  lpper;
        logic [1:0]                  mask;
        logic [1:0]                  flags;  // [1] close, [0] away
        logic                        near;
        logic [11:0]                 data;
        logic [pti_pkg::DATA_W-1:0]  rdata;
        logic                        int_n;
        logic                        irq;
    } pti_core_s;

    localparam pti_core_s CORE_RST = '{
        meth:    pti_pkg::RST_METH,
        mask:    pti_pkg::RST_MASK,
        thdh:    pti_pkg::RST_THDH,
        int_n:   1'b1,
        default: '0
    };

    pti_core_s st_reg;
    pti_core_s st_next;

    logic       close_hit;
    logic       away_hit;
    logic       close_fire;
    logic       away_fire;
    logic       close_ev;
    logic       away_ev;
    logic       enabled;
    logic       flag_rd;
    logic [1:0] flag_clr;

    // ------------------------------------------------------------
    // Threshold compare and persistence
    // ------------------------------------------------------------
    // Logic mode trips on reaching the upper level, others above it
    assign close_hit = (st_reg.meth == pti_pkg::METH_LOGIC) ?
                       (meas_in.count >= st_reg.thdh) :
                       (meas_in.count > st_reg.thdh);
    assign away_hit  = meas_in.count < st_reg.thdl;

    pti_persist u_close (
        .mclk_in  (mclk_in),
        .rstn_in  (rstn_in),
        .step_in  (meas_in.valid),
        .hit_in   (close_hit),
        .pers_in  (st_reg.pers),
        .fire_out (close_fire)
    );

    pti_persist u_away (
        .mclk_in  (mclk_in),
        .rstn_in  (rstn_in),
        .step_in  (meas_in.valid),
        .hit_in   (away_hit),
        .pers_in  (st_reg.pers),
        .fire_out (away_fire)
    );

    // Periodic request while low power is on
    pti_lp_timer #(
        .BASE_CYC (LP_BASE_CYC)
    ) u_timer (
        .mclk_in  (mclk_in),
        .rstn_in  (rstn_in),
        .en_in    (st_reg.lpen),
        .per_in   (st_reg.lpper),
        .tick_out (meas_req_out)
    );

    // ------------------------------------------------------------
    // Events
    // ------------------------------------------------------------
    assign enabled = st_reg.meth != pti_pkg::METH_OFF;

    // Close only on entry, so a dip into the band cannot re-fire
    assign close_ev = close_fire && !st_reg.near && enabled;
    // Away needs a prior close except in normal mode
    assign away_ev  = away_fire && enabled &&
                      (st_reg.near ||
                       st_reg.meth == pti_pkg::METH_NORMAL);

    // Reading the flag word clears it; a one written also clears
    assign flag_rd  = bus_in.rd && bus_in.addr == pti_pkg::ADDR_FLAG;
    assign flag_clr = (flag_rd ? 2'h3 : 2'h0) |
                      ((bus_in.wr && bus_in.addr == pti_pkg::ADDR_FLAG) ?
                       bus_in.wdata[pti_pkg::AWAY_BIT +: 2] : 2'h0);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        // Register writes
        if (bus_in.wr) begin
            case (bus_in.addr)
                pti_pkg::ADDR_CONF2: begin
                    st_next.meth = bus_in.wdata[pti_pkg::METH_LSB +: 2];
                    st_next.pers = bus_in.wdata[pti_pkg::PERS_LSB +: 2];
                end
                pti_pkg::ADDR_THDL: begin
                    st_next.thdl = bus_in.wdata[11:0];
                end
                pti_pkg::ADDR_THDH: begin
                    st_next.thdh = bus_in.wdata[11:0];
                end
                pti_pkg::ADDR_LP: begin
                    st_next.lpen  = bus_in.wdata[pti_pkg::LPEN_BIT];
                    st_next.lpper = bus_in.wdata[pti_pkg::LPPER_LSB +: 2];
                end
                pti_pkg::ADDR_MASK: begin
                    st_next.mask = bus_in.wdata[pti_pkg::AWAY_BIT +: 2];
                end
                default: begin
                end
            endcase
        end
        // Latest sample for readback
        if (meas_in.valid) begin
            st_next.data = meas_in.count;
        end
        // Set wins over a clear in the same cycle
        st_next.flags = (st_reg.flags & ~flag_clr) |
                        {close_ev, away_ev};
        // Proximity state tracks the hysteresis band
        if (!enabled) begin
            st_next.near = 1'b0;
        end else if (close_ev) begin
            st_next.near = 1'b1;
        end else if (away_fire) begin
            st_next.near = 1'b0;
        end
        // Read data for the cycle after the strobe only
        st_next.rdata = '0;
        if (bus_in.rd) begin
            case (bus_in.addr)
                pti_pkg::ADDR_CONF2: begin
                    st_next.rdata[pti_pkg::METH_LSB +: 2] = st_reg.meth;
                    st_next.rdata[pti_pkg::PERS_LSB +: 2] = st_reg.pers;
                end
                pti_pkg::ADDR_THDL: begin
                    st_next.rdata[11:0] = st_reg.thdl;
                end
                pti_pkg::ADDR_THDH: begin
                    st_next.rdata[11:0] = st_reg.thdh;
                end
                pti_pkg::ADDR_LP: begin
                    st_next.rdata[pti_pkg::LPEN_BIT] = st_reg.lpen;
                    st_next.rdata[pti_pkg::LPPER_LSB +: 2] = st_reg.lpper;
                end
                pti_pkg::ADDR_MASK: begin
                    st_next.rdata[pti_pkg::AWAY_BIT +: 2] = st_reg.mask;
                end
                pti_pkg::ADDR_DATA: begin
                    st_next.rdata[11:0] = st_reg.data;
                end
                pti_pkg::ADDR_FLAG: begin
                    st_next.rdata[pti_pkg::AWAY_BIT +: 2] = st_reg.flags;
                end
                pti_pkg::ADDR_ID: begin
                    st_next.rdata = pti_pkg::DEVICE_ID;
                end
                default: begin
                end
            endcase
        end
        // Pin level from the new state, low means pending
        case (st_next.meth)
            pti_pkg::METH_LOGIC: begin
                st_next.int_n = !st_next.near;
            end
            pti_pkg::METH_FIRST, pti_pkg::METH_NORMAL: begin
                st_next.int_n = !(|(st_next.flags & st_next.mask));
            end
            default: begin
                st_next.int_n = 1'b1;
            end
        endcase
        st_next.irq = |(st_next.flags & st_next.mask);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_reg <= CORE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata_out = st_reg.rdata;
    assign int_n_out = st_reg.int_n;
    assign irq_out   = st_reg.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rstn_in);

    // Logic mode counts reaching the upper level as outside the band
    logic in_band;
    assign in_band = meas_in.count <= st_reg.thdh &&
                     meas_in.count >= st_reg.thdl &&
                     !(st_reg.meth == pti_pkg::METH_LOGIC &&
                       meas_in.count == st_reg.thdh);

    off_pin_high_a: assert property (
        st_reg.meth == pti_pkg::METH_OFF |-> st_reg.int_n)
        else $error("pin low with interrupts off");
    first_upper_a: assert property (
        (st_reg.meth == pti_pkg::METH_FIRST && !st_reg.near &&
         st_reg.flags == 2'h0) |=> !st_reg.flags[0])
        else $error("first-high started on a low event");
    first_ignore_low_a: assert property (
        (st_reg.meth == pti_pkg::METH_FIRST && away_fire &&
         !st_reg.near) |=> !$rose(st_reg.flags[0]))
        else $error("low crossing seen before first high");
    flag_hold_a: assert property (
        (st_reg.flags[1] && !flag_clr[1]) |=> st_reg.flags[1])
        else $error("close flag lost without a read");
    normal_pin_a: assert property (
        (st_reg.meth == pti_pkg::METH_NORMAL &&
         |(st_reg.flags & st_reg.mask)) |-> !int_n_out)
        else $error("normal mode pin not asserted");
    logic_low_a: assert property (
        (st_reg.meth == pti_pkg::METH_LOGIC && close_fire &&
         !bus_in.wr) |=> !int_n_out)
        else $error("logic mode pin not pulled low");
    logic_release_a: assert property (
        (st_reg.meth == pti_pkg::METH_LOGIC && !st_reg.int_n &&
         !away_fire && !bus_in.wr) |=> !st_reg.int_n)
        else $error("logic mode pin released early");
    band_quiet_a: assert property (
        (meas_in.valid && in_band) |=> ##1
        (st_reg.flags & ~$past(st_reg.flags)) == 2'h0)
        else $error("event from an in-band sample");
    close_flag_a: assert property (
        (close_fire && enabled && !st_reg.near) |=> st_reg.flags[1])
        else $error("close flag not set");
    first_away_a: assert property (
        (st_reg.meth == pti_pkg::METH_FIRST && st_reg.near &&
         away_fire) |=> st_reg.flags[0])
        else $error("away after first high not flagged");
    off_quiet_a: assert property (
        (st_reg.meth == pti_pkg::METH_OFF && st_reg.flags == 2'h0) |=>
        st_reg.flags == 2'h0)
        else $error("flag set with interrupts off");
    read_clear_a: assert property (
        (flag_rd && !close_ev && !away_ev) |=> st_reg.flags == 2'h0)
        else $error("flag read did not clear");
    pin_idle_a: assert property (
        (st_reg.meth != pti_pkg::METH_LOGIC &&
         (st_reg.flags & st_reg.mask) == 2'h0) |-> int_n_out)
        else $error("pin low with nothing pending");

    logic_pin_c: cover property (
        st_reg.meth == pti_pkg::METH_LOGIC && $fell(st_reg.int_n));
    first_close_c: cover property (
        st_reg.meth == pti_pkg::METH_FIRST && $rose(st_reg.flags[1]));
    read_clear_c: cover property (
        flag_rd && st_reg.flags != 2'h0 ##1 st_reg.flags == 2'h0);
    lp_tick_c: cover property (meas_req_out);
    away_set_c: cover property ($rose(st_reg.flags[0]));

endmodule // pti_prox_irq

// File: tb/pti_meas_model.sv
// Measurement front-end model that answers the core's period requests
module pti_meas_model (
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rstn_in,
    // Requests from the core and the bench
    input  wire logic        req_in,
    input  wire logic        shot_in,
    input  wire logic        slow_in,
    input  wire logic [11:0] val_in,
    // Measurement result
    output pti_pkg::meas_s   meas_out
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] wait_reg;

    // Answer a request after one or three cycles, or a bench shot at once
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wait_reg <= 2'h0;
            meas_out <= '0;
        end else begin
            // Count toggles outside valid, so a stale value never helps
            meas_out.valid <= 1'b0;
            meas_out.count <= ~meas_out.count;
            if (req_in) begin
                wait_reg <= slow_in ? 2'h3 : 2'h1;
            end else if (wait_reg != 2'h0) begin
                wait_reg <= wait_reg - 2'h1;
            end
            if (shot_in || wait_reg == 2'h1) begin
                meas_out.valid <= 1'b1;
                meas_out.count <= val_in;
            end
        end
    end
endmodule // pti_meas_model

// File: tb/tb_top.sv
// Self-checking bench of the proximity threshold interrupt core
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    // ---------------------------------------------------------------
    // Signals and instances
    // ---------------------------------------------------------------
    localparam int unsigned BASE    = 8;
    localparam logic [15:0] CLOSE_F = 16'h0200;
    localparam logic [15:0] AWAY_F  = 16'h0100;

    logic                       mclk_in = 1'b0;
    logic                       rstn_in = 1'b0;
    pti_pkg::bus_req_s          bus_in  = '0;
    logic [pti_pkg::DATA_W-1:0] rdata_out;
    pti_pkg::meas_s             meas_in;
    logic                       meas_req_out;
    logic                       int_n_out;
    logic                       irq_out;
    logic                       shot = 1'b0;
    logic                       slow = 1'b0;
    logic [11:0]                val  = 12'h000;
    logic [7:0]                 rnd  = 8'h3a;
    int                         err_total = 0;
    int                         samples_checked = 0;
    int                         cyc = 0;
    int                         n;

    // Short base period keeps the low-power timer test brief
    always #50 mclk_in = ~mclk_in;

    pti_prox_irq #(.LP_BASE_CYC(BASE)) u_pti_prox_irq (
        .mclk_in(mclk_in), .rstn_in(rstn_in), .bus_in(bus_in),
        .rdata_out(rdata_out), .meas_in(meas_in),
        .meas_req_out(meas_req_out), .int_n_out(int_n_out),
        .irq_out(irq_out));

    pti_meas_model u_pti_meas_model (
        .mclk_in(mclk_in), .rstn_in(rstn_in), .req_in(meas_req_out),
        .shot_in(shot), .slow_in(slow), .val_in(val), .meas_out(meas_in));

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Configuration word: persistence in 5:4, method in 3:2
    function automatic logic [15:0] conf(input logic [1:0] meth, pers);
        return {10'h000, pers, meth, 2'h0};
    endfunction

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        bus_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk_in);
        bus_in <= '0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rc(input string nm, input logic [7:0] a,
                      input logic [15:0] e);
        logic [15:0] d;
        @(posedge mclk_in);
        bus_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge mclk_in);
        bus_in <= '0;
        @(negedge mclk_in);
        d = rdata_out;
        chk(nm, d, e);
    endtask

    task automatic m(input logic [11:0] v);
        @(posedge mclk_in);
        shot <= 1'b1;
        val  <= v;
        @(posedge mclk_in);
        shot <= 1'b0;
        repeat (4) @(posedge mclk_in);
    endtask

    // Pins change on the same edge as a flag clear; two falling edges pass before the check
    task automatic pin(input logic [1:0] e);
        repeat (2) @(negedge mclk_in);
        chk("int_n_irq", {14'h0, int_n_out, irq_out}, {14'h0, e});
    endtask

    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            finish_test();
        end
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (5) @(posedge mclk_in);
        rstn_in <= 1'b1;
        pin(2'b10);
        rc("thdh", pti_pkg::ADDR_THDH, 16'h0fff);
        rc("mask", pti_pkg::ADDR_MASK, 16'h0300);
        rc("flag", pti_pkg::ADDR_FLAG, 16'h0000);
        rc("id", pti_pkg::ADDR_ID, pti_pkg::DEVICE_ID);
        rc("unmapped", 8'h77, 16'h0000);
        wr(pti_pkg::ADDR_THDL, 16'h0064);
        wr(pti_pkg::ADDR_THDH, 16'h00c8);
        rc("thdl", pti_pkg::ADDR_THDL, 16'h0064);
        // Method off raises nothing
        m(12'd300);
        pin(2'b10);
        // Normal method, write-one clear of the away flag
        wr(pti_pkg::ADDR_CONF2, conf(pti_pkg::METH_NORMAL, 2'h0));
        rc("conf", pti_pkg::ADDR_CONF2, conf(pti_pkg::METH_NORMAL, 2'h0));
        m(12'd150);
        pin(2'b10);
        m(12'd201);
        pin(2'b01);
        rc("flag", pti_pkg::ADDR_FLAG, CLOSE_F);
        pin(2'b10);
        m(12'd50);
        pin(2'b01);
        wr(pti_pkg::ADDR_FLAG, AWAY_F);
        rc("flag", pti_pkg::ADDR_FLAG, 16'h0000);
        for (int i = 0; i < 12; i++) begin
            rnd = lfsr(rnd);
            m(12'd100 + 12'(rnd % 8'd101));
            pin(2'b10);
        end
        // First-high: low crossing ignored, event held until read
        wr(pti_pkg::ADDR_CONF2, conf(pti_pkg::METH_FIRST, 2'h0));
        m(12'd50);
        pin(2'b10);
        rc("flag", pti_pkg::ADDR_FLAG, 16'h0000);
        m(12'd201);
        repeat (20) @(negedge mclk_in);
        pin(2'b01);
        rc("flag", pti_pkg::ADDR_FLAG, CLOSE_F);
        pin(2'b10);
        m(12'd50);
        rc("flag", pti_pkg::ADDR_FLAG, AWAY_F);
        // Logic method: low from the upper threshold, high below lower
        wr(pti_pkg::ADDR_CONF2, conf(pti_pkg::METH_LOGIC, 2'h0));
        m(12'd200);
        pin(2'b01);
        rc("flag", pti_pkg::ADDR_FLAG, CLOSE_F);
        pin(2'b00);
        m(12'd150);
        m(12'd100);
        pin(2'b00);
        m(12'd99);
        pin(2'b11);
        rc("flag", pti_pkg::ADDR_FLAG, AWAY_F);
        // Persistence: a broken run starts the count again
        for (int p = 1; p < 4; p++) begin
            wr(pti_pkg::ADDR_CONF2, conf(pti_pkg::METH_NORMAL, 2'(p)));
            repeat (p) m(12'd201);
            m(12'd150);
            repeat (p) m(12'd201);
            rc("flag", pti_pkg::ADDR_FLAG, 16'h0000);
            m(12'd201);
            rc("flag", pti_pkg::ADDR_FLAG, CLOSE_F);
            repeat (p + 1) m(12'd50);
            rc("flag", pti_pkg::ADDR_FLAG, AWAY_F);
        end
        // Masked close leaves the level output quiet
        wr(pti_pkg::ADDR_CONF2, conf(pti_pkg::METH_NORMAL, 2'h0));
        wr(pti_pkg::ADDR_MASK, AWAY_F);
        m(12'd201);
        pin(2'b10);
        rc("flag", pti_pkg::ADDR_FLAG, CLOSE_F);
        m(12'd50);
        pin(2'b01);
        rc("flag", pti_pkg::ADDR_FLAG, AWAY_F);
        wr(pti_pkg::ADDR_MASK, 16'h0300);
        // Low-power periods, partner answering fast and slow
        for (int p = 0; p < 4; p++) begin
            val  <= 12'd150;
            slow <= p[1];
            wr(pti_pkg::ADDR_LP, 16'h0100 | 16'(p << 9));
            rc("lp", pti_pkg::ADDR_LP, 16'h0100 | 16'(p << 9));
            for (int k = 0; k < 3; k++) begin
                n = 0;
                do begin
                    @(posedge mclk_in);
                    n++;
                end while (meas_req_out !== 1'b1 && n < 400);
            end
            chk("period", 16'(n), 16'(BASE << p));
        end
        wr(pti_pkg::ADDR_LP, 16'h0000);
        repeat (6) @(posedge mclk_in);
        rc("data", pti_pkg::ADDR_DATA, 16'h0096);
        n = 0;
        repeat (80) begin
            @(posedge mclk_in);
            if (meas_req_out !== 1'b0) n++;
        end
        chk("idle_req", 16'(n), 16'h0000);
        finish_test();
    end
endmodule // tb_top
